// ===== hdl/mrc_pkg.sv
package mrc_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] MRC_CTRL_OFS = 8'h00;
  localparam logic [7:0] MRC_DIS_STATE_OFS = 8'h04;
  localparam logic [7:0] MRC_STATUS_OFS = 8'h08;
  localparam logic [7:0] MRC_IRQ_STS_OFS = 8'h0c;
  localparam logic [7:0] MRC_IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] MRC_IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] MRC_ID_OFS = 8'h18;
  localparam logic [7:0] MRC_GPIO_FUNC_OFS = 8'h20;
  localparam logic [7:0] MRC_ADDR_STEP = 8'h04;

  // ==========================================================================
  // Field positions
  localparam int MRC_CTRL_GATE_BIT = 0;
  localparam int MRC_CTRL_EEPROM_BIT = 1;
  localparam int MRC_ST_READY_BIT = 0;
  localparam int MRC_ST_DONE_BIT = 1;
  localparam int MRC_ST_SEQ_BIT = 2;
  localparam int MRC_ST_POR_BIT = 3;
  localparam int MRC_ST_PIN_BIT = 4;
  localparam int MRC_IRQ_SEQ_BIT = 0;
  localparam int MRC_IRQ_DONE_BIT = 1;
  localparam int MRC_IRQ_POR_BIT = 2;
  localparam int MRC_IRQ_LOSS_BIT = 3;
  localparam int MRC_IRQ_W = 4;
  localparam int MRC_DIS_W = 2;
  localparam int MRC_FUNC_W = 5;

  // ==========================================================================
  // Reset values and codes
  localparam logic [1:0] MRC_CTRL_RST = 2'h1;
  localparam logic [MRC_FUNC_W-1:0] MRC_FUNC_READY = 5'h18;
  localparam logic [MRC_FUNC_W-1:0] MRC_FUNC_RST = 5'h00;
  // Identity value is arbitrary
  localparam logic [15:0] MRC_ID_DEFAULT = 16'h5a01;

  // ==========================================================================
  // Timing
  localparam int MRC_CLK_PERIOD_NS = 10;
  localparam int MRC_POR_DELAY_MS = 5;
  localparam int MRC_POR_DELAY_CYC = MRC_POR_DELAY_MS * 1000000 / MRC_CLK_PERIOD_NS;
  localparam int MRC_SEQ_CYC = 16;

  typedef enum logic [4:0] {
    MRC_S_NOPOR = 5'h01,
    MRC_S_WAITHI = 5'h02,
    MRC_S_SEQ = 5'h04,
    MRC_S_LOAD = 5'h08,
    MRC_S_READY = 5'h10
  } mrc_state_t;
endpackage : mrc_pkg

// ===== hdl/mrc_master_reset_ctrl.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
// Operation
// - Internal POR 5 ms after supplies good
// - First sequence at POR if pin high
// - Later sequences on pin low-then-high
// - Pin low at POR defers sequence
// - Startup gating field disables outputs during sequence
// - Disabled output idles per own field
// - Serial access only once ready, except status reads
// - GPIO function 0x18 mirrors ready
// - Reset-done flag set on sequence end
// - Configuration from OTP or EEPROM
module mrc_master_reset_ctrl import mrc_pkg::*; #(
  parameter int NUM_OUT = 12,
  parameter int NUM_GPIO = 6,
  parameter int POR_DELAY_CYC = MRC_POR_DELAY_CYC,
  parameter int SEQ_CYC = MRC_SEQ_CYC,
  parameter logic [15:0] DEVICE_ID = MRC_ID_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic supplyAGood,
  input wire logic supplyBGood,
  input wire logic extResetLowPin,
  output logic cfgLoadReq_q,
  output logic cfgFromEeprom_q,
  input wire logic cfgLoadDone,
  output logic serialReady_q,
  output logic [NUM_OUT-1:0] clkOutEn_q,
  output logic [NUM_OUT*MRC_DIS_W-1:0] clkOutIdle_q,
  output logic [NUM_GPIO-1:0] gpioOut_q,
  output logic [NUM_GPIO-1:0] gpioOe_q,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata_q,
  output logic irq_q
);
  localparam int POR_W = $clog2(POR_DELAY_CYC + 1);
  localparam int SEQ_W = $clog2(SEQ_CYC + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_DELAY_CYC - 1);
  localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(SEQ_CYC - 1);

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ofs);
    isAddr = (a == ofs);
  endfunction : isAddr

  // ==========================================================================
  // Input synchronisers
  logic [1:0] supA_q, supB_q, pin_q;
  logic pinPrev_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      supA_q <= 2'h0;
      supB_q <= 2'h0;
      // Pin idles high on its pull-up, so reset makes no false edge
      pin_q <= 2'h3;
      pinPrev_q <= 1'b1;
    end else if (clkEn) begin
      supA_q <= {supA_q[0], supplyAGood};
      supB_q <= {supB_q[0], supplyBGood};
      pin_q <= {pin_q[0], extResetLowPin};
      pinPrev_q <= pin_q[1];
    end
  end

  logic pinHigh, pinRise, suppliesOk;
  assign pinHigh = pin_q[1];
  assign pinRise = pin_q[1] & ~pinPrev_q;
  assign suppliesOk = supA_q[1] & supB_q[1];

  // ==========================================================================
  // Power-on reset delay
  logic [POR_W-1:0] porCnt_q;
  logic por_q;
  // Any supply dip restarts the whole delay
  // delay after both supplies good
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      porCnt_q <= '0;
      por_q <= 1'b0;
    end else if (clkEn) begin
      if (!suppliesOk) begin
        porCnt_q <= '0;
        por_q <= 1'b0;
      end else if (!por_q) begin
        if (porCnt_q == POR_LAST) begin
          por_q <= 1'b1;
        end else begin
          porCnt_q <= porCnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Register storage
  logic [1:0] ctrl_q;
  logic [NUM_OUT*MRC_DIS_W-1:0] disState_q;
  logic [MRC_FUNC_W-1:0] gpioFunc_q [NUM_GPIO];
  logic [MRC_IRQ_W-1:0] irqSts_q, irqEn_q;
  logic wrOk, rdOk;
  logic ready;

  // Early writes are dropped, never held for later
  // accesses refused until ready, except status reads
  assign wrOk = regWr & ready;
  assign rdOk = regRd & (ready | isAddr(regAddr, MRC_STATUS_OFS));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= MRC_CTRL_RST;
      disState_q <= '0;
      irqEn_q <= '0;
    end else if (clkEn && wrOk) begin
      if (isAddr(regAddr, MRC_CTRL_OFS)) begin
        ctrl_q <= regWdata[1:0];
      end
      if (isAddr(regAddr, MRC_DIS_STATE_OFS)) begin
        disState_q <= regWdata[NUM_OUT*MRC_DIS_W-1:0];
      end
      if (isAddr(regAddr, MRC_IRQ_EN_OFS)) begin
        irqEn_q <= regWdata[MRC_IRQ_W-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GPIO; g++) begin : gFunc
      localparam logic [7:0] OFS = MRC_GPIO_FUNC_OFS + 8'(g) * MRC_ADDR_STEP;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          gpioFunc_q[g] <= MRC_FUNC_RST;
        end else if (clkEn && wrOk && isAddr(regAddr, OFS)) begin
          gpioFunc_q[g] <= regWdata[MRC_FUNC_W-1:0];
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          gpioOut_q[g] <= 1'b0;
          gpioOe_q[g] <= 1'b0;
        end else if (clkEn) begin
          // Enable follows the function alone, not readiness
          gpioOe_q[g] <= (gpioFunc_q[g] == MRC_FUNC_READY);
          gpioOut_q[g] <= (gpioFunc_q[g] == MRC_FUNC_READY) & ready;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Master reset sequencer
  mrc_state_t state_q;
  logic [SEQ_W-1:0] seqCnt_q;
  logic seqStart, seqEnd, porRise, porFall, porSeen_q;
  logic rstDone_q;

  assign ready = (state_q == MRC_S_READY);
  assign porRise = por_q & ~porSeen_q;
  assign porFall = ~por_q & porSeen_q;
  // A restart or supply loss in the same cycle cancels the end
  assign seqEnd = (state_q == MRC_S_LOAD) & cfgLoadDone & por_q & ~seqStart;
  assign seqStart = ((state_q == MRC_S_NOPOR) & por_q & pinHigh)
    | ((state_q == MRC_S_WAITHI) & pinHigh)
    | ((state_q == MRC_S_SEQ || state_q == MRC_S_LOAD || state_q == MRC_S_READY)
       & pinRise);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= MRC_S_NOPOR;
      seqCnt_q <= '0;
      porSeen_q <= 1'b0;
    end else if (clkEn) begin
      porSeen_q <= por_q;
      if (!por_q) begin
        state_q <= MRC_S_NOPOR;
      end else if (seqStart) begin
        state_q <= MRC_S_SEQ;
        seqCnt_q <= '0;
      end else begin
        case (state_q)
          MRC_S_NOPOR: begin
            state_q <= MRC_S_WAITHI;
          end
          MRC_S_WAITHI: begin
            state_q <= MRC_S_WAITHI;
          end
          MRC_S_SEQ: begin
            if (seqCnt_q == SEQ_LAST) begin
              state_q <= MRC_S_LOAD;
            end else begin
              seqCnt_q <= seqCnt_q + 1'b1;
            end
          end
          MRC_S_LOAD: begin
            if (cfgLoadDone) begin
              state_q <= MRC_S_READY;
            end
          end
          MRC_S_READY: begin
            state_q <= MRC_S_READY;
          end
          default: begin
            state_q <= MRC_S_NOPOR;
          end
        endcase
      end
    end
  end

  // Source is latched during the sequence, before the request
  // load request with source select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfgLoadReq_q <= 1'b0;
      cfgFromEeprom_q <= 1'b0;
    end else if (clkEn) begin
      cfgLoadReq_q <= (state_q == MRC_S_SEQ) & (seqCnt_q == SEQ_LAST) & ~seqStart & por_q;
      if (state_q == MRC_S_SEQ) begin
        cfgFromEeprom_q <= ctrl_q[MRC_CTRL_EEPROM_BIT];
      end
    end
  end

  // done flag set at sequence end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rstDone_q <= 1'b0;
    end else if (clkEn) begin
      if (seqEnd) begin
        rstDone_q <= 1'b1;
      end else if (seqStart || !por_q) begin
        rstDone_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Clock output gating
  // Gating covers every state short of ready
  logic inSeq;
  assign inSeq = (state_q != MRC_S_READY);
  generate
    for (g = 0; g < NUM_OUT; g++) begin : gOut
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          clkOutEn_q[g] <= 1'b0;
          clkOutIdle_q[g*MRC_DIS_W +: MRC_DIS_W] <= '0;
        end else if (clkEn) begin
          clkOutEn_q[g] <= ~(inSeq & ctrl_q[MRC_CTRL_GATE_BIT]);
          clkOutIdle_q[g*MRC_DIS_W +: MRC_DIS_W] <= disState_q[g*MRC_DIS_W +: MRC_DIS_W];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Interrupts
  logic [MRC_IRQ_W-1:0] irqEvt, irqClr;
  always_comb begin
    irqEvt = '0;
    irqEvt[MRC_IRQ_SEQ_BIT] = seqStart & por_q;
    irqEvt[MRC_IRQ_DONE_BIT] = seqEnd & ~seqStart;
    irqEvt[MRC_IRQ_POR_BIT] = porRise;
    irqEvt[MRC_IRQ_LOSS_BIT] = porFall;
  end
  assign irqClr = (wrOk && isAddr(regAddr, MRC_IRQ_CLR_OFS)) ? regWdata[MRC_IRQ_W-1:0] : '0;

  // Set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqSts_q <= '0;
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irqSts_q <= (irqSts_q & ~irqClr) | irqEvt;
      // Output lags status by one cycle
      irq_q <= |(irqSts_q & irqEn_q);
    end
  end

  // ==========================================================================
  // Read path and ready output
  logic [31:0] rdMux;
  integer i;
  always_comb begin
    rdMux = '0;
    if (isAddr(regAddr, MRC_CTRL_OFS)) begin
      rdMux[1:0] = ctrl_q;
    end
    if (isAddr(regAddr, MRC_DIS_STATE_OFS)) begin
      rdMux[NUM_OUT*MRC_DIS_W-1:0] = disState_q;
    end
    if (isAddr(regAddr, MRC_STATUS_OFS)) begin
      rdMux[MRC_ST_READY_BIT] = ready;
      rdMux[MRC_ST_DONE_BIT] = rstDone_q;
      rdMux[MRC_ST_SEQ_BIT] = (state_q == MRC_S_SEQ) | (state_q == MRC_S_LOAD);
      rdMux[MRC_ST_POR_BIT] = por_q;
      rdMux[MRC_ST_PIN_BIT] = pinHigh;
    end
    if (isAddr(regAddr, MRC_IRQ_STS_OFS)) begin
      rdMux[MRC_IRQ_W-1:0] = irqSts_q;
    end
    if (isAddr(regAddr, MRC_IRQ_EN_OFS)) begin
      rdMux[MRC_IRQ_W-1:0] = irqEn_q;
    end
    if (isAddr(regAddr, MRC_ID_OFS)) begin
      rdMux[15:0] = DEVICE_ID;
    end
    // Function slots sit one address step apart
    for (i = 0; i < NUM_GPIO; i++) begin
      if (isAddr(regAddr, MRC_GPIO_FUNC_OFS + 8'(i) * MRC_ADDR_STEP)) begin
        rdMux[MRC_FUNC_W-1:0] = gpioFunc_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdata_q <= '0;
      serialReady_q <= 1'b0;
    end else if (clkEn) begin
      // Refused reads return zero
      regRdata_q <= rdOk ? rdMux : '0;
      serialReady_q <= ready;
    end
  end
endmodule : mrc_master_reset_ctrl

// ===== sim/mrc_checker_sva.sv
`timescale 1ns/1ps
module mrc_checker_sva #(
  parameter int NUM_OUT = 12,
  parameter int NUM_GPIO = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic supplyAGood,
  input wire logic extResetLowPin,
  input wire logic cfgLoadDone,
  input wire logic cfgLoadReq_q,
  input wire logic serialReady_q,
  input wire logic [NUM_OUT-1:0] clkOutEn_q,
  input wire logic [NUM_GPIO-1:0] gpioOut_q,
  input wire logic [NUM_GPIO-1:0] gpioOe_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Sequencer
  supply_loss_a: assert property (
    $fell(supplyAGood) |-> ##[1:6] !serialReady_q) else $error("ready kept after supply loss");
  restart_seq_a: assert property (
    $rose(extResetLowPin) && !$past(extResetLowPin, 2) && serialReady_q |-> ##[1:8] !serialReady_q)
    else $error("pin release did not restart");
  ready_hold_a: assert property (
    $fell(serialReady_q) |-> !serialReady_q [*5]) else $error("ready back too soon");
  ready_cause_a: assert property (
    $rose(serialReady_q) |-> $past(cfgLoadDone, 2)) else $error("ready without load done");
  load_pulse_a: assert property (
    cfgLoadReq_q |=> !cfgLoadReq_q) else $error("load request too long");
  load_busy_a: assert property (
    cfgLoadReq_q |-> !serialReady_q) else $error("ready during load");
  outputs_run_a: assert property (
    serialReady_q |-> &clkOutEn_q) else $error("outputs off while ready");
  gpio_ready_a: assert property (
    gpioOe_q[0] |-> gpioOut_q[0] == serialReady_q) else $error("gpio not tracking ready");
endmodule : mrc_checker_sva

bind mrc_master_reset_ctrl mrc_checker_sva #(.NUM_OUT(NUM_OUT), .NUM_GPIO(NUM_GPIO)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .supplyAGood(supplyAGood), .extResetLowPin(extResetLowPin),
  .cfgLoadDone(cfgLoadDone), .cfgLoadReq_q(cfgLoadReq_q), .serialReady_q(serialReady_q),
  .clkOutEn_q(clkOutEn_q), .gpioOut_q(gpioOut_q), .gpioOe_q(gpioOe_q));

// ===== sim/mrc_board.sv
`timescale 1ns/1ps
module mrc_board (
  input wire logic clk_sys,
  input wire logic cfgLoadReq_q,
  output logic supplyAGood,
  output logic supplyBGood,
  output logic extResetLowPin,
  output logic cfgLoadDone
);
  int lag = 0;
  int cnt = -1;
  initial begin
    supplyAGood = 1'b0;
    supplyBGood = 1'b0;
    extResetLowPin = 1'b1;
  end
  // ==========================================================================
  // Supplies and reset pin
  task automatic power(input logic on);
    @(posedge clk_sys);
    supplyAGood <= on;
    supplyBGood <= on;
  endtask : power
  task automatic setPin(input logic v);
    @(posedge clk_sys);
    extResetLowPin <= v;
  endtask : setPin
  // low two cycles or more, pulsed only once ready
  task automatic pinLow(input int n);
    setPin(1'b0);
    repeat (n) @(posedge clk_sys);
    extResetLowPin <= 1'b1;
  endtask : pinLow
  // ==========================================================================
  // Loader, slow or prompt by lag
  always @(posedge clk_sys) begin
    cfgLoadDone <= (cnt == 0);
    cnt <= cfgLoadReq_q ? lag : (cnt > 0 ? cnt - 1 : -1);
  end
endmodule : mrc_board

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench import mrc_pkg::*; ();
  localparam int POR_CYC = 20;
  localparam int SEQ = 4;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic supplyAGood, supplyBGood, extResetLowPin, cfgLoadDone, cfgLoadReq_q, cfgFromEeprom_q;
  logic serialReady_q, irq_q;
  logic [11:0] clkOutEn_q;
  logic [23:0] clkOutIdle_q;
  logic [5:0] gpioOut_q, gpioOe_q;
  logic [31:0] regRdata_q;
  int error_cnt = 0;
  int checks_done = 0;

  mrc_master_reset_ctrl #(.POR_DELAY_CYC(POR_CYC), .SEQ_CYC(SEQ)) mrc_master_reset_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .supplyAGood(supplyAGood),
    .supplyBGood(supplyBGood), .extResetLowPin(extResetLowPin), .cfgLoadReq_q(cfgLoadReq_q),
    .cfgFromEeprom_q(cfgFromEeprom_q), .cfgLoadDone(cfgLoadDone), .serialReady_q(serialReady_q),
    .clkOutEn_q(clkOutEn_q), .clkOutIdle_q(clkOutIdle_q), .gpioOut_q(gpioOut_q),
    .gpioOe_q(gpioOe_q), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata_q(regRdata_q), .irq_q(irq_q));
  mrc_board mrc_board_i (.clk_sys(clk_sys), .cfgLoadReq_q(cfgLoadReq_q),
    .supplyAGood(supplyAGood), .supplyBGood(supplyBGood), .extResetLowPin(extResetLowPin),
    .cfgLoadDone(cfgLoadDone));

  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] stsExp(input bit rdy, input bit pin);
    return (32'(rdy) << MRC_ST_READY_BIT) | (32'(rdy) << MRC_ST_DONE_BIT)
      | (32'h1 << MRC_ST_POR_BIT) | (32'(pin) << MRC_ST_PIN_BIT);
  endfunction : stsExp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata_q;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wt(input bit req, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
      if (n > 300) begin
        error_cnt++;
        results();
      end
    end while ((req ? cfgLoadReq_q : serialReady_q) !== 1'b1);
  endtask : wt
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] v, d;
    int n;
    n = $urandom(81);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    mrc_board_i.setPin(1'b0);
    mrc_board_i.power(1'b1);
    wr(MRC_CTRL_OFS, 32'h0);
    cyc(40);
    chk(serialReady_q, 1'b0);
    rd(MRC_STATUS_OFS, v);
    chk(v, stsExp(0, 0));
    mrc_board_i.setPin(1'b1);
    wt(0, n);
    rd(MRC_CTRL_OFS, v);
    chk(v, 32'(MRC_CTRL_RST));
    rd(8'h1c, v);
    chk(v, 32'h0);
    rd(MRC_ID_OFS, v);
    chk(v, 32'(MRC_ID_DEFAULT));
    mrc_board_i.power(1'b0);
    cyc(6);
    chk(serialReady_q, 1'b0);
    mrc_board_i.power(1'b1);
    wt(1, n);
    // Sync stages and whole sequence sit on top of the delay
    chk(n >= POR_CYC + SEQ && n <= POR_CYC + SEQ + 8, 1'b1);
    wt(0, n);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'(MRC_FUNC_READY) : 32'($urandom_range(31));
      wr(8'(MRC_GPIO_FUNC_OFS + MRC_ADDR_STEP * i), v);
      cyc(2);
      chk({gpioOe_q[i], gpioOut_q[i]}, {2{v[4:0] == MRC_FUNC_READY}});
    end
    for (int g = 0; g < 2; g++) begin
      d = $urandom() & 32'h00ff_ffff;
      wr(MRC_DIS_STATE_OFS, d);
      wr(MRC_CTRL_OFS, (32'(1 - g) << MRC_CTRL_GATE_BIT) | (32'(g) << MRC_CTRL_EEPROM_BIT));
      wr(MRC_IRQ_CLR_OFS, 32'hf);
      wr(MRC_IRQ_EN_OFS, 32'h1 << MRC_IRQ_DONE_BIT);
      mrc_board_i.lag = $urandom_range(5);
      mrc_board_i.pinLow($urandom_range(2, 5));
      wt(1, n);
      chk(clkOutEn_q, g ? 32'hfff : 32'h0);
      chk(clkOutIdle_q, d);
      chk(cfgFromEeprom_q, 32'(g));
      wt(0, n);
      rd(MRC_STATUS_OFS, v);
      chk(v, stsExp(1, 1));
      chk(irq_q, 1'b1);
      wr(MRC_IRQ_EN_OFS, 32'h0);
      cyc(1);
      chk(irq_q, 1'b0);
      wr(MRC_IRQ_EN_OFS, 32'h1 << MRC_IRQ_DONE_BIT);
      cyc(1);
      chk(irq_q, 1'b1);
      wr(MRC_IRQ_CLR_OFS, 32'h1 << MRC_IRQ_DONE_BIT);
      cyc(1);
      chk(irq_q, 1'b0);
    end
    results();
  end
endmodule : testbench
